// >>> rtl/tvic_pkg.sv
package tvic_pkg;
    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_GATE_EXTRA = 8'hA7;
    localparam logic [7:0] IDX_GATE_MAIN = 8'hA8;
    localparam logic [7:0] IDX_LEVEL_EXTRA = 8'hB7;
    localparam logic [7:0] IDX_LEVEL_MAIN = 8'hB8;
    localparam int ADDR_W = 12;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] MASK_GATE_MAIN = 8'hBF;
    localparam logic [7:0] MASK_LEVEL_MAIN = 8'h3F;
    localparam logic [7:0] MASK_EXTRA = 8'h13;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_GLOBAL = 7;
    localparam int BIT_T2 = 5;
    localparam int BIT_U1 = 4;
    localparam int BIT_T1 = 3;
    localparam int BIT_X1 = 2;
    localparam int BIT_T0 = 1;
    localparam int BIT_X0 = 0;
    localparam int BIT_U2 = 4;
    localparam int BIT_TWI = 1;
    localparam int BIT_USB = 0;

    // ------------------------------------------------------------
    // polling positions, 0 highest
    // ------------------------------------------------------------
    localparam int NSRC = 10;
    localparam int POS_X0 = 0;
    localparam int POS_U2 = 1;
    localparam int POS_T0 = 2;
    localparam int POS_TWI = 3;
    localparam int POS_X1 = 4;
    localparam int POS_RSV = 5;
    localparam int POS_T1 = 6;
    localparam int POS_USB = 7;
    localparam int POS_U1 = 8;
    localparam int POS_T2 = 9;

    // ------------------------------------------------------------
    // vectors and timing
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_X0 = 16'h0003;
    localparam logic [15:0] VEC_T0 = 16'h000B;
    localparam logic [15:0] VEC_X1 = 16'h0013;
    localparam logic [15:0] VEC_T1 = 16'h001B;
    localparam logic [15:0] VEC_U1 = 16'h0023;
    localparam logic [15:0] VEC_T2 = 16'h002B;
    localparam logic [15:0] VEC_USB = 16'h0033;
    localparam logic [15:0] VEC_TWI = 16'h0043;
    localparam logic [15:0] VEC_U2 = 16'h004B;
    localparam logic [15:0] VEC_NONE = 16'h0000;
    localparam int MC_PCLKS = 12;

    typedef enum logic [1:0] {
        NEST_NONE,
        NEST_LOW,
        NEST_HIGH,
        NEST_BOTH
    } tvic_nest_t;
endpackage : tvic_pkg

// >>> rtl/tvic_mc_div.sv
`timescale 1ns/10ps
module tvic_mc_div #(
    parameter int MC_PCLKS = tvic_pkg::MC_PCLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick
);
    import tvic_pkg::*;

    // ------------------------------------------------------------
    // machine cycle divider
    // ------------------------------------------------------------
    logic [7:0] cnt_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg <= 8'h00;
            tick <= 1'b0;
        end else if (cnt_reg == 8'(MC_PCLKS - 1)) begin
            cnt_reg <= 8'h00;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
            tick <= 1'b0;
        end
    end
endmodule : tvic_mc_div

// >>> rtl/tvic_pick.sv
`timescale 1ns/10ps
module tvic_pick (
    input wire logic [tvic_pkg::NSRC-1:0] req,
    input wire logic [tvic_pkg::NSRC-1:0] level,
    output logic found,
    output logic is_high,
    output logic [3:0] pos
);
    import tvic_pkg::*;

    // ------------------------------------------------------------
    // lowest set position wins
    // ------------------------------------------------------------
    function automatic logic [3:0] first_set(input logic [NSRC-1:0] v);
        logic [3:0] p;
        p = 4'h0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                p = 4'(i);
            end
        end
        return p;
    endfunction : first_set

    logic [NSRC-1:0] hi_req;

    always_comb begin
        hi_req = req & level;
        found = |req;
        is_high = |hi_req;
        if (is_high) begin
            pos = first_set(hi_req);
        end else begin
            pos = first_set(req);
        end
    end
endmodule : tvic_pick

// >>> rtl/tvic_ctrl.sv
`timescale 1ns/10ps
// Functional notes
// (R01) serial request is receive OR transmit done
// (R02) software clears serial flags itself
// (R03) one priority bit per source, 1 high
// (R04) high preempts low, nothing preempts high
// (R05) high level wins, ties by polling order
// (R06) fixed polling order, position 0 highest
// (R07) per-source enables plus global gate bit 7
// (R08) main enable register bit layout
// (R09) extra enable register bit layout
// (R10) priority registers mirror enable layouts
// (R11) evaluate previous machine cycle's samples
// (R12) withhold call on nesting, mid-instruction, interrupt_exit_instr, access
// (R13) no memory of unserviced requests
// (R14) push pc, flags word not saved, load vector
// (R15) fixed vector per source
// (R16) interrupt return clears level, pops pc
// (R17) plain return leaves in-progress set
// (R18) external flag cleared on vector only if edge
// (R19) timer 0 and 1 flags cleared on service
// (R20) software clears timer 2 flag
// (R21) reserved slot silent, registers reset to zero
// (R22) separate low and high in-progress indicators
module tvic_ctrl #(
    parameter int MC_PCLKS = tvic_pkg::MC_PCLKS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tvic_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext0_request_flag,
    input wire logic ext1_request_flag,
    input wire logic ext0_edge_select,
    input wire logic ext1_edge_select,
    input wire logic timer0_overflow_flag,
    input wire logic timer1_overflow_flag,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_capture_flag,
    input wire logic uart1_receive_done_flag,
    input wire logic uart1_transmit_done_flag,
    input wire logic uart2_receive_done_flag,
    input wire logic uart2_transmit_done_flag,
    input wire logic twi_request_flag,
    input wire logic usb_request_flag,
    input wire logic instr_last_cycle,
    input wire logic interrupt_exit_instr,
    input wire logic plain_subroutine_exit,
    input wire logic instr_gate_access,
    input wire logic [15:0] current_pc,
    output logic flag_sample_phase,
    output logic long_subroutine_call,
    output logic [15:0] call_vector,
    output logic [15:0] stack_push_pc,
    output logic pc_pop,
    output logic ext0_flag_clr,
    output logic ext1_flag_clr,
    output logic timer0_flag_clr,
    output logic timer1_flag_clr,
    output logic in_progress_low,
    output logic in_progress_high
);
    import tvic_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [NSRC-1:0] to_poll(input logic [7:0] m,
                                                input logic [7:0] x);
        logic [NSRC-1:0] v;
        v = '0;
        v[POS_X0] = m[BIT_X0];
        v[POS_U2] = x[BIT_U2];
        v[POS_T0] = m[BIT_T0];
        v[POS_TWI] = x[BIT_TWI];
        v[POS_X1] = m[BIT_X1];
        v[POS_RSV] = 1'b0;
        v[POS_T1] = m[BIT_T1];
        v[POS_USB] = x[BIT_USB];
        v[POS_U1] = m[BIT_U1];
        v[POS_T2] = m[BIT_T2];
        return v;
    endfunction : to_poll

    function automatic logic [15:0] vector_of(input logic [3:0] p);
        logic [15:0] v;
        case (p)
            4'(POS_X0): v = VEC_X0;
            4'(POS_U2): v = VEC_U2;
            4'(POS_T0): v = VEC_T0;
            4'(POS_TWI): v = VEC_TWI;
            4'(POS_X1): v = VEC_X1;
            4'(POS_T1): v = VEC_T1;
            4'(POS_USB): v = VEC_USB;
            4'(POS_U1): v = VEC_U1;
            4'(POS_T2): v = VEC_T2;
            default: v = VEC_NONE;
        endcase
        return v;
    endfunction : vector_of

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] gate_main_reg;
    logic [7:0] gate_extra_reg;
    logic [7:0] level_main_reg;
    logic [7:0] level_extra_reg;
    logic [NSRC-1:0] sample_reg;
    logic [NSRC-1:0] raw_flags;
    logic [NSRC-1:0] enabled;
    logic [NSRC-1:0] levels;
    logic tick;
    logic found;
    logic win_high;
    logic [3:0] win_pos;
    logic nest_ok;
    logic take;
    logic interrupt_exit_instr_now;
    tvic_nest_t nest_reg;
    tvic_nest_t nest_next;

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic addr_ok;
    logic [7:0] idx;
    logic [7:0] rd_byte;

    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        idx = paddr[9:2];
        addr_ok = (paddr[ADDR_W-1:10] == '0) && (paddr[1:0] == 2'b00)
            && (idx == IDX_GATE_MAIN || idx == IDX_GATE_EXTRA
            || idx == IDX_LEVEL_MAIN || idx == IDX_LEVEL_EXTRA);
        case (idx)
            IDX_GATE_MAIN: rd_byte = gate_main_reg;
            IDX_GATE_EXTRA: rd_byte = gate_extra_reg;
            IDX_LEVEL_MAIN: rd_byte = level_main_reg;
            IDX_LEVEL_EXTRA: rd_byte = level_extra_reg;
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (setup) begin
                pslverr <= !addr_ok;
                prdata <= (addr_ok && !pwrite) ? {24'h000000, rd_byte}
                                               : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gate_main_reg <= REG_RESET; // [R21]
            gate_extra_reg <= REG_RESET;
            level_main_reg <= REG_RESET;
            level_extra_reg <= REG_RESET;
        end else if (access && pready && pwrite && addr_ok) begin
            case (idx)
                IDX_GATE_MAIN: gate_main_reg <= pwdata[7:0] & MASK_GATE_MAIN;
                IDX_GATE_EXTRA: gate_extra_reg <= pwdata[7:0] & MASK_EXTRA;
                IDX_LEVEL_MAIN: level_main_reg <= pwdata[7:0] & MASK_LEVEL_MAIN;
                IDX_LEVEL_EXTRA: level_extra_reg <= pwdata[7:0] & MASK_EXTRA;
                default: gate_main_reg <= gate_main_reg;
            endcase
        end
    end

    // ------------------------------------------------------------
    // sampling
    // ------------------------------------------------------------
    tvic_mc_div #(
        .MC_PCLKS(MC_PCLKS)
    ) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick(tick)
    );

    always_comb begin
        raw_flags = '0;
        raw_flags[POS_X0] = ext0_request_flag;
        raw_flags[POS_U2] = uart2_receive_done_flag
            | uart2_transmit_done_flag; // [R01]
        raw_flags[POS_T0] = timer0_overflow_flag;
        raw_flags[POS_TWI] = twi_request_flag;
        raw_flags[POS_X1] = ext1_request_flag;
        raw_flags[POS_RSV] = 1'b0; // [R21]
        raw_flags[POS_T1] = timer1_overflow_flag;
        raw_flags[POS_USB] = usb_request_flag;
        raw_flags[POS_U1] = uart1_receive_done_flag
            | uart1_transmit_done_flag; // [R01]
        raw_flags[POS_T2] = timer2_overflow_flag | timer2_capture_flag;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_reg <= '0;
            flag_sample_phase <= 1'b0;
        end else begin
            flag_sample_phase <= tick;
            if (tick) begin
                sample_reg <= raw_flags; // [R11] [R13]
            end
        end
    end

    // ------------------------------------------------------------
    // polling and blocking
    // ------------------------------------------------------------
    always_comb begin
        enabled = to_poll(gate_main_reg, gate_extra_reg); // [R08] [R09]
        levels = to_poll(level_main_reg, level_extra_reg); // [R03] [R10]
    end

    tvic_pick u_pick (
        .req(sample_reg & enabled & {NSRC{gate_main_reg[BIT_GLOBAL]}}),
        .level(levels),
        .found(found),
        .is_high(win_high),
        .pos(win_pos)
    ); // [R05] [R06] [R07]

    always_comb begin
        if (win_high) begin
            nest_ok = (nest_reg == NEST_NONE)
                || (nest_reg == NEST_LOW); // [R04]
        end else begin
            nest_ok = (nest_reg == NEST_NONE);
        end
        take = tick && found && nest_ok && instr_last_cycle
            && !interrupt_exit_instr && !instr_gate_access; // [R12]
        interrupt_exit_instr_now = tick && instr_last_cycle && interrupt_exit_instr;
    end

    // ------------------------------------------------------------
    // nesting state
    // ------------------------------------------------------------
    always_comb begin
        nest_next = nest_reg;
        if (take) begin
            case (nest_reg)
                NEST_NONE: nest_next = win_high ? NEST_HIGH : NEST_LOW;
                NEST_LOW: nest_next = NEST_BOTH;
                default: nest_next = nest_reg;
            endcase
        end else if (interrupt_exit_instr_now) begin
            case (nest_reg)
                NEST_BOTH: nest_next = NEST_LOW; // [R22]
                NEST_HIGH: nest_next = NEST_NONE;
                NEST_LOW: nest_next = NEST_NONE; // [R16]
                default: nest_next = NEST_NONE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nest_reg <= NEST_NONE;
            in_progress_low <= 1'b0;
            in_progress_high <= 1'b0;
        end else begin
            nest_reg <= nest_next; // [R17]
            in_progress_low <= (nest_next == NEST_LOW)
                || (nest_next == NEST_BOTH);
            in_progress_high <= (nest_next == NEST_HIGH)
                || (nest_next == NEST_BOTH);
        end
    end

    // ------------------------------------------------------------
    // call, return and flag clears
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            long_subroutine_call <= 1'b0;
            call_vector <= VEC_NONE;
            stack_push_pc <= 16'h0000;
            pc_pop <= 1'b0;
        end else begin
            long_subroutine_call <= take;
            pc_pop <= interrupt_exit_instr_now; // [R16]
            if (take) begin
                call_vector <= vector_of(win_pos); // [R15]
                stack_push_pc <= current_pc; // [R14]
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext0_flag_clr <= 1'b0;
            ext1_flag_clr <= 1'b0;
            timer0_flag_clr <= 1'b0;
            timer1_flag_clr <= 1'b0;
        end else begin
            ext0_flag_clr <= take && win_pos == 4'(POS_X0)
                && ext0_edge_select; // [R18]
            ext1_flag_clr <= take && win_pos == 4'(POS_X1)
                && ext1_edge_select; // [R18]
            timer0_flag_clr <= take && win_pos == 4'(POS_T0); // [R19]
            timer1_flag_clr <= take && win_pos == 4'(POS_T1); // [R19]
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_call_cond;
        $past(instr_last_cycle) && !$past(interrupt_exit_instr)
            && !$past(instr_gate_access);
    endsequence

    property p_gate;
        @(posedge pclk) disable iff (!presetn)
        long_subroutine_call |-> $past(gate_main_reg[BIT_GLOBAL]);
    endproperty
    a_gate: assert property (p_gate) // [R07]
        else $error("call taken with global gate clear");

    property p_no_preempt_high;
        @(posedge pclk) disable iff (!presetn)
        long_subroutine_call |-> !$past(in_progress_high);
    endproperty
    a_no_preempt_high: assert property (p_no_preempt_high) // [R04]
        else $error("call taken during high routine");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        long_subroutine_call |-> s_call_cond;
    endproperty
    a_block: assert property (p_block) // [R12]
        else $error("call taken while blocked");

    property p_tick;
        @(posedge pclk) disable iff (!presetn)
        long_subroutine_call |-> flag_sample_phase;
    endproperty
    a_tick: assert property (p_tick) // [R11]
        else $error("call not aligned to machine cycle");

    property p_vector;
        @(posedge pclk) disable iff (!presetn)
        long_subroutine_call |-> call_vector[2:0] == 3'h3
            && call_vector[15:7] == 9'h000;
    endproperty
    a_vector: assert property (p_vector) // [R15]
        else $error("bad call vector");

    property p_nest_set;
        @(posedge pclk) disable iff (!presetn)
        long_subroutine_call |-> in_progress_low || in_progress_high;
    endproperty
    a_nest_set: assert property (p_nest_set) // [R22]
        else $error("no in-progress level after call");

    property p_interrupt_exit_instr;
        @(posedge pclk) disable iff (!presetn)
        interrupt_exit_instr_now && nest_reg == NEST_HIGH |=> pc_pop && !in_progress_high;
    endproperty
    a_interrupt_exit_instr: assert property (p_interrupt_exit_instr) // [R16]
        else $error("interrupt return did not clear high level");

    property p_plain_ret;
        @(posedge pclk) disable iff (!presetn)
        tick && plain_subroutine_exit && !interrupt_exit_instr && !take
            |=> $stable(in_progress_low) && $stable(in_progress_high);
    endproperty
    a_plain_ret: assert property (p_plain_ret) // [R17]
        else $error("plain return changed in-progress state");

    property p_ext_clr;
        @(posedge pclk) disable iff (!presetn)
        ext0_flag_clr |-> long_subroutine_call && call_vector == VEC_X0
            && $past(ext0_edge_select);
    endproperty
    a_ext_clr: assert property (p_ext_clr) // [R18]
        else $error("external flag cleared without edge vectoring");
endmodule : tvic_ctrl

// >>> tb/tvic_core_model.sv
`timescale 1ns/10ps
// ------------------------------------------------------------
// core sequencer and request flag model
// ------------------------------------------------------------
module tvic_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] flag_set,
    input wire logic [11:0] flag_sw_clr,
    input wire logic [3:0] flag_hw_clr,
    input wire logic long_subroutine_call,
    input wire logic pc_pop,
    output logic [11:0] flags,
    output logic [3:0] stack_depth
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= 12'h000;
        end else begin
            flags <= (flags | flag_set) & ~flag_sw_clr
                & ~{8'h00, flag_hw_clr};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stack_depth <= 4'h0;
        end else begin
            stack_depth <= stack_depth + 4'(long_subroutine_call)
                - 4'(pc_pop);
        end
    end
endmodule : tvic_core_model

// >>> tb/tvic_ctrl_tb_top.sv
`timescale 1ns/10ps
module tvic_ctrl_tb_top;
    import tvic_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] r;
        logic [11:0] fl;
        logic [15:0] vec;
        logic hi;
    } tvic_row_t;
    localparam int MCP = 3;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, plain_subroutine_exit = 1'b0;
    logic [11:0] paddr = 12'h000, fset = 12'h000, fclr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic instr_last_cycle = 1'b1, ext0_edge_select = 1'b1;
    logic ext1_edge_select = 1'b0, interrupt_exit_instr = 1'b0;
    logic instr_gate_access = 1'b0;
    logic [15:0] current_pc = 16'h1000;
    logic [31:0] prdata, rd;
    logic [15:0] call_vector, stack_push_pc;
    logic pready, pslverr, long_subroutine_call, pc_pop, er, fsp;
    logic in_progress_low, in_progress_high;
    wire logic [11:0] fl;
    wire logic [3:0] hclr, depth;
    int fails = 0, checks = 0, cycles = 0;
    logic [7:0] idxs [4] = '{IDX_GATE_MAIN, IDX_GATE_EXTRA,
        IDX_LEVEL_MAIN, IDX_LEVEL_EXTRA};
    logic [7:0] msks [4] = '{MASK_GATE_MAIN, MASK_EXTRA,
        MASK_LEVEL_MAIN, MASK_EXTRA};
    tvic_row_t rows [20] = '{
        '{32'h81000000, 12'h001, VEC_X0, 1'b0},
        '{32'h82000000, 12'h004, VEC_T0, 1'b0},
        '{32'h84000000, 12'h002, VEC_X1, 1'b0},
        '{32'h88000000, 12'h008, VEC_T1, 1'b0},
        '{32'h90000000, 12'h040, VEC_U1, 1'b0},
        '{32'h90000000, 12'h080, VEC_U1, 1'b0},
        '{32'hA0000000, 12'h020, VEC_T2, 1'b0},
        '{32'h80010000, 12'h800, VEC_USB, 1'b0},
        '{32'h80020000, 12'h400, VEC_TWI, 1'b0},
        '{32'h80100000, 12'h200, VEC_U2, 1'b0},
        '{32'hBF130000, 12'hFFF, VEC_X0, 1'b0},
        '{32'hBE130000, 12'hFFF, VEC_U2, 1'b0},
        '{32'h84020000, 12'hFFF, VEC_TWI, 1'b0},
        '{32'hB8010000, 12'hFFF, VEC_T1, 1'b0},
        '{32'hB0000000, 12'hFFF, VEC_U1, 1'b0},
        '{32'hBF132000, 12'hFFF, VEC_T2, 1'b1},
        '{32'hBF130001, 12'hFFF, VEC_USB, 1'b1},
        '{32'hBF130800, 12'h00C, VEC_T1, 1'b1},
        '{32'h3F133F13, 12'hFFF, VEC_NONE, 1'b0},
        '{32'hBF000000, 12'hF00, VEC_NONE, 1'b0}};

    always #4 pclk = ~pclk;

    tvic_ctrl #(.MC_PCLKS(MCP)) i_tvic_ctrl (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .ext0_edge_select, .ext1_edge_select,
        .ext0_request_flag(fl[0]), .ext1_request_flag(fl[1]),
        .timer0_overflow_flag(fl[2]), .timer1_overflow_flag(fl[3]),
        .timer2_overflow_flag(fl[4]), .timer2_capture_flag(fl[5]),
        .uart1_receive_done_flag(fl[6]), .uart1_transmit_done_flag(fl[7]),
        .uart2_receive_done_flag(fl[8]), .uart2_transmit_done_flag(fl[9]),
        .twi_request_flag(fl[10]), .usb_request_flag(fl[11]),
        .instr_last_cycle, .interrupt_exit_instr, .plain_subroutine_exit,
        .instr_gate_access, .current_pc, .flag_sample_phase(fsp),
        .long_subroutine_call, .call_vector, .stack_push_pc, .pc_pop,
        .ext0_flag_clr(hclr[0]), .ext1_flag_clr(hclr[1]),
        .timer0_flag_clr(hclr[2]), .timer1_flag_clr(hclr[3]),
        .in_progress_low, .in_progress_high);

    tvic_core_model i_tvic_core_model (
        .pclk, .presetn, .flag_set(fset), .flag_sw_clr(fclr),
        .flag_hw_clr(hclr), .long_subroutine_call, .pc_pop,
        .flags(fl), .stack_depth(depth));

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: %s got %0h", $time, msg, got);
        end
    endtask : chk

    task automatic finish_test;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : finish_test

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, {2'b00, idx, 2'b00}, d);
    endtask : wr

    task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
        apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
        chk(rd, {24'h000000, e}, "register");
    endtask : rdc

    task automatic set_flags(input logic [11:0] v);
        fset <= v;
        @(posedge pclk);
        fset <= 12'h000;
    endtask : set_flags

    task automatic clear_flags;
        fclr <= 12'hFFF;
        repeat (4 * MCP) @(posedge pclk);
        fclr <= 12'h000;
    endtask : clear_flags

    task automatic irq_return;
        interrupt_exit_instr <= 1'b1;
        for (int n = 0; n < 40 && pc_pop !== 1'b1; n++) begin
            @(posedge pclk);
        end
        interrupt_exit_instr <= 1'b0;
        chk(32'(pc_pop), 32'h1, "pop");
        @(posedge pclk);
    endtask : irq_return

    task automatic serve(input logic [15:0] ev, input logic [1:0] elev);
        logic seen = 1'b0;
        logic [15:0] gv, gp;
        logic [4:0] gc, ec;
        ec = {1'b1, ev == VEC_T1, ev == VEC_T0,
              ev == VEC_X1 && ext1_edge_select,
              ev == VEC_X0 && ext0_edge_select};
        for (int n = 0; n < 40 && seen !== 1'b1; n++) begin
            @(posedge pclk);
            seen = long_subroutine_call;
            gv = call_vector;
            gp = stack_push_pc;
            gc = {fsp, hclr};
        end
        chk(32'(seen), 32'(ev != VEC_NONE), "call");
        if (seen === 1'b1) begin
            chk(32'(gv), 32'(ev), "vector");
            chk(32'(gp), 32'(current_pc), "push");
            chk(32'(gc), 32'(ec), "clears");
            @(posedge pclk);
            chk(32'({in_progress_high, in_progress_low}),
                32'(elev), "level");
        end
    endtask : serve

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (rows[i]) begin
            current_pc <= 16'h1000 + 16'(i);
            for (int k = 0; k < 4; k++) begin
                wr(idxs[k], rows[i].r[8*(3-k)+:8]);
            end
            set_flags(rows[i].fl);
            serve(rows[i].vec, {rows[i].hi, !rows[i].hi});
            clear_flags();
            if (rows[i].vec !== VEC_NONE) begin
                irq_return();
            end
        end
        // nesting
        wr(IDX_GATE_MAIN, 8'h8A);
        wr(IDX_LEVEL_MAIN, 8'h08);
        set_flags(12'h004);
        serve(VEC_T0, 2'b01);
        set_flags(12'h008);
        serve(VEC_T1, 2'b11);
        chk(32'(depth), 32'h2, "stack depth");
        set_flags(12'h004);
        serve(VEC_NONE, 2'b11);
        irq_return();
        chk(32'({in_progress_high, in_progress_low}), 32'h1, "lvl");
        serve(VEC_NONE, 2'b01);
        plain_subroutine_exit <= 1'b1;
        repeat (2 * MCP) @(posedge pclk);
        plain_subroutine_exit <= 1'b0;
        chk(32'(in_progress_low), 32'h1, "plain exit");
        irq_return();
        serve(VEC_T0, 2'b01);
        clear_flags();
        irq_return();
        chk(32'(depth), 32'h0, "stack depth");
        // blocking
        wr(IDX_GATE_MAIN, 8'h81);
        instr_last_cycle <= 1'b0;
        set_flags(12'h001);
        serve(VEC_NONE, 2'b00);
        clear_flags();
        instr_last_cycle <= 1'b1;
        serve(VEC_NONE, 2'b00);
        instr_gate_access <= 1'b1;
        set_flags(12'h001);
        serve(VEC_NONE, 2'b00);
        instr_gate_access <= 1'b0;
        serve(VEC_X0, 2'b01);
        clear_flags();
        irq_return();
        // masks, unmapped, reset
        for (int k = 0; k < 4; k++) begin
            wr(idxs[k], 8'hFF);
            rdc(idxs[k], msks[k]);
        end
        apb(1'b0, 12'h004, 8'h00);
        chk(32'(er), 32'h1, "unmapped");
        presetn <= 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            rdc(idxs[k], REG_RESET);
        end
        finish_test();
    end
endmodule : tvic_ctrl_tb_top
